// [logic/blit_setup_map.vh]
`ifndef BLIT_SETUP_MAP_VH
`define BLIT_SETUP_MAP_VH

`define OFS_PATTERN_X     7'h74
`define OFS_PATTERN_Y     7'h76
`define OFS_TARGET_X      7'h78
`define OFS_TARGET_Y      7'h7A
`define OFS_OPERATION     7'h7C

`define COORD_RESET       16'h0000
`define OPCTL_RESET       32'h00000000

`define F_BG_HI           31
`define F_BG_LO           30
`define F_FG_HI           29
`define F_FG_LO           28
`define F_FUNC_HI         27
`define F_FUNC_LO         24
`define F_SRC_HI          23
`define F_SRC_LO          20
`define F_DST_HI          19
`define F_DST_LO          16
`define F_PAT_HI          15
`define F_PAT_LO          12
`define F_MASK_HI         7
`define F_MASK_LO         6
`define F_DRAW_HI         5
`define F_DRAW_LO         4
`define F_AXIS_SWAP       0
`define F_VERT_DIR        1
`define F_HORIZ_DIR       2

`define SRCSEL_COLOUR     2'h0
`define SRCSEL_MAP        2'h2

`define FN_DRAW_ADV_RD    4'h2
`define FN_LINE_RD        4'h3
`define FN_DRAW_ADV_WR    4'h4
`define FN_LINE_WR        4'h5
`define FN_BLOCK_XFER     4'h8
`define FN_BLOCK_INV      4'h9
`define FN_BLOCK_FILL     4'hA

`define MAP_A             4'h1
`define MAP_B             4'h2
`define MAP_C             4'h3
`define PAT_FIXED_FG      4'h8
`define PAT_FROM_SRC      4'h9

`define MASK_OFF          2'h0
`define MASK_BOUNDARY     2'h1
`define MASK_ON           2'h2

`endif

// [logic/blit_operation_setup_regs.v]
`timescale 1ns/1ps
`include "blit_setup_map.vh"

module blit_operation_setup_regs (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [6:0]  reg_addr,
  input  wire [3:0]  reg_be,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  input  wire        dir_advance_wr,
  input  wire        engine_busy,
  output wire        start_pulse,
  output wire        busy,
  output wire [1:0]  bg_source_select,
  output wire [1:0]  fg_source_select,
  output wire [3:0]  func_code,
  output wire [3:0]  src_map_sel,
  output wire [3:0]  dst_map_sel,
  output wire [3:0]  pat_map_sel,
  output wire [1:0]  mask_mode,
  output wire [1:0]  draw_attr_mode,
  output wire        axis_swap_flag,
  output wire        vertical_direction_flag,
  output wire        horizontal_direction_flag,
  output wire        bg_from_map,
  output wire        fg_from_map,
  output wire        pat_forced_fg,
  output wire        pat_from_source,
  output wire        pixel_block_transfer,
  output wire        line_op,
  output wire        draw_advance_op,
  output wire        func_reserved,
  output wire        map_sel_reserved,
  output wire [15:0] pattern_x,
  output wire [15:0] pattern_y,
  output wire [15:0] target_x,
  output wire [15:0] target_y
);

  reg  [15:0] pattern_x_coord_q;
  reg  [15:0] pattern_y_coord_q;
  reg  [15:0] target_x_coord_q;
  reg  [15:0] target_y_coord_q;
  reg  [31:0] operation_control_q;
  reg         start_q;
  reg         active_q;
  wire        sel_px;
  wire        sel_py;
  wire        sel_tx;
  wire        sel_ty;
  wire        sel_op;
  wire        op_wr;
  wire        top_byte_wr;
  wire        launch_any;
  wire        launch_now;
  wire        advance_now;

  // half-word registers: one per offset, written via lanes 1:0 only; lanes 3:2 are ignored
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  function map_ok;
    input [3:0] code;
    begin
      map_ok = (code == `MAP_A) || (code == `MAP_B) || (code == `MAP_C);
    end
  endfunction

  assign sel_px = (reg_addr == `OFS_PATTERN_X);
  assign sel_py = (reg_addr == `OFS_PATTERN_Y);
  assign sel_tx = (reg_addr == `OFS_TARGET_X);
  assign sel_ty = (reg_addr == `OFS_TARGET_Y);
  assign sel_op = (reg_addr == `OFS_OPERATION);

  // byte lanes map straight onto bits, no swap for either host byte order
  assign op_wr       = reg_wr && sel_op && !active_q;
  assign top_byte_wr = op_wr && reg_be[3];
  assign launch_any  = top_byte_wr;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      pattern_x_coord_q   <= `COORD_RESET;
      pattern_y_coord_q   <= `COORD_RESET;
      target_x_coord_q    <= `COORD_RESET;
      target_y_coord_q    <= `COORD_RESET;
      operation_control_q <= `OPCTL_RESET;
    end else if (reg_wr) begin
      if (sel_px)
        pattern_x_coord_q <= merge16(pattern_x_coord_q, reg_wdata[15:0], reg_be[1:0]);
      if (sel_py)
        pattern_y_coord_q <= merge16(pattern_y_coord_q, reg_wdata[15:0], reg_be[1:0]);
      if (sel_tx)
        target_x_coord_q <= merge16(target_x_coord_q, reg_wdata[15:0], reg_be[1:0]);
      if (sel_ty)
        target_y_coord_q <= merge16(target_y_coord_q, reg_wdata[15:0], reg_be[1:0]);
      if (op_wr) begin
        // writes during an operation are dropped so fields stay stable
        if (reg_be[0]) operation_control_q[7:0]   <= reg_wdata[7:0];
        if (reg_be[1]) operation_control_q[15:8]  <= reg_wdata[15:8];
        if (reg_be[2]) operation_control_q[23:16] <= reg_wdata[23:16];
        if (reg_be[3]) operation_control_q[31:24] <= reg_wdata[31:24];
      end
    end
  end

  // launch is decided from the freshly written function code
  wire [3:0] new_func = reg_wdata[`F_FUNC_HI:`F_FUNC_LO];
  wire       new_is_adv = (new_func == `FN_DRAW_ADV_RD) || (new_func == `FN_DRAW_ADV_WR);
  wire       new_valid  = (new_func == `FN_LINE_RD) || (new_func == `FN_LINE_WR) ||
                          (new_func == `FN_BLOCK_XFER) || (new_func == `FN_BLOCK_INV) ||
                          (new_func == `FN_BLOCK_FILL);
  assign launch_now  = launch_any && new_valid && !new_is_adv;
  assign advance_now = dir_advance_wr && !active_q && draw_advance_op;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      start_q  <= 1'b0;
      active_q <= 1'b0;
    end else begin
      start_q <= launch_now || advance_now;
      if (launch_now || advance_now)
        active_q <= 1'b1;
      else if (!start_q && !engine_busy)
        active_q <= 1'b0;
    end
  end

  assign start_pulse = start_q;
  assign busy        = active_q;

  always @(posedge clk_sys) begin
    if (!nrst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      // operation control is write only and reads as zero
      case (1'b1)
        sel_px:  reg_rdata <= {16'h0000, pattern_x_coord_q};
        sel_py:  reg_rdata <= {16'h0000, pattern_y_coord_q};
        sel_tx:  reg_rdata <= {16'h0000, target_x_coord_q};
        sel_ty:  reg_rdata <= {16'h0000, target_y_coord_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  assign bg_source_select = operation_control_q[`F_BG_HI:`F_BG_LO];
  assign fg_source_select = operation_control_q[`F_FG_HI:`F_FG_LO];
  assign bg_from_map      = (bg_source_select == `SRCSEL_MAP);
  assign fg_from_map      = (fg_source_select == `SRCSEL_MAP);
  assign func_code        = operation_control_q[`F_FUNC_HI:`F_FUNC_LO];
  assign src_map_sel      = operation_control_q[`F_SRC_HI:`F_SRC_LO];
  assign dst_map_sel      = operation_control_q[`F_DST_HI:`F_DST_LO];
  assign pat_map_sel      = operation_control_q[`F_PAT_HI:`F_PAT_LO];
  assign mask_mode        = operation_control_q[`F_MASK_HI:`F_MASK_LO];
  assign draw_attr_mode   = operation_control_q[`F_DRAW_HI:`F_DRAW_LO];
  assign axis_swap_flag            = operation_control_q[`F_AXIS_SWAP];
  assign vertical_direction_flag   = operation_control_q[`F_VERT_DIR];
  assign horizontal_direction_flag = operation_control_q[`F_HORIZ_DIR];
  assign pat_forced_fg    = (pat_map_sel == `PAT_FIXED_FG);
  assign pat_from_source  = (pat_map_sel == `PAT_FROM_SRC);

  assign pixel_block_transfer = (func_code == `FN_BLOCK_XFER) || (func_code == `FN_BLOCK_INV) ||
                                (func_code == `FN_BLOCK_FILL);
  assign line_op         = (func_code == `FN_LINE_RD) || (func_code == `FN_LINE_WR);
  assign draw_advance_op = (func_code == `FN_DRAW_ADV_RD) ||
                           (func_code == `FN_DRAW_ADV_WR);
  assign func_reserved   = !(pixel_block_transfer || line_op || draw_advance_op);
  // reserved codes are flagged, not trapped; unused bits 11-8 and 3 are ignored
  assign map_sel_reserved = !map_ok(src_map_sel) || !map_ok(dst_map_sel) ||
                            !(map_ok(pat_map_sel) || pat_forced_fg || pat_from_source) ||
                            (mask_mode == 2'h3) || bg_source_select[0] ||
                            fg_source_select[0];

  assign pattern_x = pattern_x_coord_q;
  assign pattern_y = pattern_y_coord_q;
  assign target_x  = target_x_coord_q;
  assign target_y  = target_y_coord_q;

endmodule // blit_operation_setup_regs

// [verif/blit_operation_setup_regs_assertions.sv]
`timescale 1ns/1ps
module blit_setup_checker (
  input wire        clk_sys,
  input wire        nrst,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [6:0]  reg_addr,
  input wire [3:0]  reg_be,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        dir_advance_wr,
  input wire        start_pulse,
  input wire        busy,
  input wire [3:0]  func_code,
  input wire [1:0]  bg_source_select,
  input wire        horizontal_direction_flag,
  input wire        draw_advance_op,
  input wire        pixel_block_transfer,
  input wire        bg_from_map
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire wr_op = reg_wr && reg_addr == 7'h7C;
  property p_launch; wr_op && reg_be[3] && !busy &&
    (reg_wdata[27:24] inside {4'h3, 4'h5, 4'h8, 4'h9, 4'hA}) |=> start_pulse; endproperty
  a_launch: assert property (p_launch) else $error("no start after launch");
  property p_low; wr_op && !reg_be[3] && !dir_advance_wr |=> !start_pulse; endproperty
  a_low: assert property (p_low) else $error("low byte write started");
  property p_dadv_wr; wr_op && (reg_wdata[27:24] inside {4'h2, 4'h4}) && !dir_advance_wr
    |=> !start_pulse; endproperty
  a_dadv_wr: assert property (p_dadv_wr) else $error("draw step started by write");
  property p_dadv; dir_advance_wr && draw_advance_op && !busy && !wr_op |=> start_pulse;
  endproperty
  a_dadv: assert property (p_dadv) else $error("direction write gave no start");
  property p_start_busy; start_pulse |-> busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_frozen; busy |=> $stable(func_code) && $stable(bg_source_select) &&
    $stable(horizontal_direction_flag); endproperty
  a_frozen: assert property (p_frozen) else $error("control changed while busy");
  property p_store; wr_op && reg_be == 4'hF && !busy |=> func_code == $past(reg_wdata[27:24])
    && horizontal_direction_flag == $past(reg_wdata[2]); endproperty
  a_store: assert property (p_store) else $error("control not stored");
  property p_wo; reg_rd && reg_addr == 7'h7C |=> reg_rdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("write only register read back");
  property p_pbt; pixel_block_transfer == (func_code inside {4'h8, 4'h9, 4'hA}); endproperty
  a_pbt: assert property (p_pbt) else $error("block transfer decode wrong");
  property p_bg; bg_from_map == (bg_source_select == 2'h2); endproperty
  a_bg: assert property (p_bg) else $error("background decode wrong");
endmodule // blit_setup_checker
bind blit_operation_setup_regs blit_setup_checker u_chk (.*);

// [verif/blit_operation_setup_regs_tb.sv]
`timescale 1ns/1ps
module blit_operation_setup_regs_tb;
  reg         clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  reg         dir_advance_wr = 0, engine_busy = 0;
  reg  [6:0]  reg_addr = 0;
  reg  [3:0]  reg_be = 0;
  reg  [31:0] reg_wdata = 0, seed = 32'h9EF0AC94, d;
  wire [31:0] reg_rdata;
  wire [15:0] pattern_x, pattern_y, target_x, target_y;
  wire [3:0]  func_code, src_map_sel, dst_map_sel, pat_map_sel;
  wire [1:0]  bg_source_select, fg_source_select, mask_mode, draw_attr_mode;
  wire        start_pulse, busy, axis_swap_flag, vertical_direction_flag;
  wire        horizontal_direction_flag, bg_from_map, fg_from_map, pat_forced_fg;
  wire        pat_from_source, pixel_block_transfer, line_op, draw_advance_op;
  wire        func_reserved, map_sel_reserved;
  integer     fail_count = 0, checks = 0, i, n;
  always #2 clk_sys = ~clk_sys;
  blit_operation_setup_regs dut (.*);
  function [31:0] rnd(input [31:0] s);
    begin
      rnd = s ^ (s << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
    end
  endfunction
  function mres(input [31:0] v);
    mres = v[30] || v[28] || v[23:20] == 0 || v[23:20] > 3 || v[19:16] == 0 ||
      v[19:16] > 3 || !(v[15:12] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9}) || v[7:6] == 2'h3;
  endfunction
  function go(input [3:0] c);
    go = c == 4'h3 || c == 4'h5 || (c >= 4'h8 && c <= 4'hA);
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // one bus cycle; the strobe is held through the taking edge
  task acc(input w, input [6:0] a, input [3:0] be, input [31:0] wd);
    begin
      @(posedge clk_sys) #1;
      {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = {w, !w, a, be, wd};
      @(posedge clk_sys) #1;
      {reg_wr, reg_rd} = 2'b00;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1;
    for (i = 0; i < 6; i = i + 1) begin
      acc(0, 7'h74 + 2 * i, 4'hF, 0);
      check(reg_rdata, 0);
    end
    $display("reset and read map test done");
    for (i = 0; i < 16; i = i + 1) begin
      seed = rnd(seed);
      d = i == 0 ? 32'hF800 : i == 1 ? 32'h17FF : i == 2 ? 32'h0FFF : seed;
      n = 7'h74 + 2 * ((i + 2) % 4);
      acc(1, n, 4'h3, d);
      acc(0, n, 4'h3, 0);
      check(reg_rdata, d[15:0]);
      check(n == 7'h74 ? pattern_x : n == 7'h76 ? pattern_y : n == 7'h78 ? target_x :
        target_y, d[15:0]);
    end
    $display("coordinate test done");
    for (i = 0; i < 16; i = i + 1) begin
      seed = rnd(seed);
      d = {seed[31:28], i[3:0], seed[23:16], i[3:0], 4'h0, seed[7:4], 1'b0, seed[2:0]};
      acc(1, 7'h7C, 4'h7, d);
      check(start_pulse, 0);
      engine_busy = 1;
      acc(1, 7'h7C, 4'h8, d);
      check(map_sel_reserved, mres(d));
      check(start_pulse, go(i));
      check({bg_source_select, fg_source_select, func_code, src_map_sel, dst_map_sel,
        pat_map_sel, mask_mode, draw_attr_mode, horizontal_direction_flag,
        vertical_direction_flag, axis_swap_flag}, {d[31:12], d[7:4], d[2:0]});
      check({bg_from_map, fg_from_map, pat_forced_fg, pat_from_source}, {d[31:30] == 2'h2,
        d[29:28] == 2'h2, i == 8, i == 9});
      check({pixel_block_transfer, line_op, draw_advance_op, func_reserved}, {i >= 8 && i <= 10,
        i == 3 || i == 5, i == 2 || i == 4, !go(i) && i != 2 && i != 4});
      if (i == 2 || i == 4) begin
        @(posedge clk_sys) #1 dir_advance_wr = 1;
        @(posedge clk_sys) #1 dir_advance_wr = 0;
        check(start_pulse, 1);
      end
      // a reserved code never launches, so the frozen check needs a started operation
      if (go(i) || i == 2 || i == 4) begin
        acc(1, 7'h7C, 4'hF, ~d);
        check(func_code, i);
      end
      engine_busy = 0;
      n = 0;
      while (busy === 1'b1 && n < 20) @(posedge clk_sys) #1 n = n + 1;
      if (n == 20) begin
        fail_count = fail_count + 1;
        tally_and_finish;
      end
      check(busy, 0);
    end
    $display("operation control test done");
    tally_and_finish;
  end
endmodule // blit_operation_setup_regs_tb
